// ===== core/tpg_pkg.sv
// constants for the triple pulse generator: io addresses, field positions,
// reset values and pin indices; assumes an 8-bit io space with 6-bit addresses
package tpg_pkg;

  // widths
  localparam int TPG_DW = 11;
  localparam int TPG_NGEN = 3;
  localparam int TPG_DIV_W = 7;

  // io addresses
  localparam logic [5:0] TPG_ADDR_CLK = 6'h21;
  localparam logic [5:0] TPG_ADDR_BND_HI = 6'h24;
  localparam logic [5:0] TPG_ADDR_BND_LO = 6'h25;
  // per generator, entry 0 is pulse_gen_zero
  localparam logic [2:0][5:0] TPG_ADDR_CTL = {6'h2c, 6'h26, 6'h20};
  localparam logic [2:0][5:0] TPG_ADDR_DTY_HI = {6'h2e, 6'h28, 6'h22};
  localparam logic [2:0][5:0] TPG_ADDR_DTY_LO = {6'h2f, 6'h29, 6'h23};

  // clock register fields
  localparam int TPG_CLK_EN_BIT = 7;
  localparam int TPG_CLK_DIV_LSB = 4;
  localparam int TPG_CLK_SRC_BIT = 0;

  // control register fields
  localparam int TPG_CTL_STAT_BIT = 6;
  localparam int TPG_CTL_INV_BIT = 5;
  localparam int TPG_CTL_MODE_BIT = 4;
  localparam int TPG_CTL_PIN_LSB = 1;
  localparam int TPG_CTL_FUNC_BIT = 0;
  // readable stored bits; bits 5 and 4 of generator zero are write only
  localparam logic [2:0][5:0] TPG_CTL_RD_MASK = {6'h3f, 6'h3f, 6'h0f};

  // low register field positions
  localparam int TPG_DTY_LO_LSB = 5;
  localparam int TPG_BND_LO_LSB = 6;

  // pin field codes
  localparam logic [2:0] TPG_PIN_OFF = 3'h0;
  localparam logic [2:0] TPG_PIN_C1 = 3'h1;
  localparam logic [2:0] TPG_PIN_C3 = 3'h3;
  localparam logic [2:0] TPG_PIN_C4 = 3'h4;
  localparam logic [2:0] TPG_PIN_C5 = 3'h5;

  // port pin indices
  localparam int TPG_PORT_A_PIN0 = 0;
  localparam int TPG_PORT_A_PIN3 = 3;
  localparam int TPG_PORT_A_PIN4 = 4;
  localparam int TPG_PORT_A_PIN5 = 5;
  localparam int TPG_PORT_B_PIN2 = 2;
  localparam int TPG_PORT_B_PIN3 = 3;
  localparam int TPG_PORT_B_PIN4 = 4;
  localparam int TPG_PORT_B_PIN5 = 5;
  localparam int TPG_PORT_B_PIN6 = 6;
  localparam int TPG_PORT_B_PIN7 = 7;

  // values after reset
  localparam logic [5:0] TPG_CTL_RST = 6'h00;
  localparam logic [7:0] TPG_CLK_RST = 8'h00;
  localparam logic [10:0] TPG_DUTY_RST = 11'h000;
  localparam logic [10:0] TPG_BOUND_RST = 11'h000;
  localparam logic [2:0] TPG_STAGE_RST = 3'h0;

endpackage

// ===== core/tpg_prescaler.sv
// power-of-two prescaler for the shared pulse counter
// assumes src_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
module tpg_prescaler
  import tpg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic src_tick,
  input wire logic [2:0] div_sel,
  // result
  output logic step_r
);

  logic [TPG_DIV_W-1:0] div_cnt_r;
  logic [TPG_DIV_W:0] span;
  logic [TPG_DIV_W-1:0] limit;
  logic at_limit;

  // code n divides by two to the n
  assign span = 8'h01 << div_sel;
  assign limit = TPG_DIV_W'(span - 8'h01);
  assign at_limit = div_cnt_r >= limit;

  // stopping clears the divider so a restart begins a whole division
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      div_cnt_r <= '0;
      step_r <= 1'b0;
    end
    else if (src_tick)
    begin
      div_cnt_r <= at_limit ? '0 : div_cnt_r + 7'h01;
      step_r <= at_limit;
    end
    else
    begin
      step_r <= 1'b0;
    end
  end

  a_step_spacing: assert property (@(posedge clk) disable iff (rst)
    (run && src_tick && div_sel == 3'h1 && div_cnt_r == 7'h00) ##1 (run && src_tick) |=> step_r)
    else $error("divide by two did not step on second source tick");

endmodule

// ===== core/tpg_top.sv
// three pulse generators sharing one 11-bit up counter, reached through io space
// assumes one io read or write per cycle and synchronous oscillator tick inputs
//
// Notes on behaviour
// - common enable bit runs or stops everything
// - three-bit prescaler divides by one to 128
// - source bit picks system clock or oscillator
// - duty high holds bits 10:3, low 2:0
// - bound high register holds bound bits 10:3
// - bound low bits 7:6 give bound bits 2:1
// - control bit 6 reads present output level
// - control bit 5 inverts generator output
// - generator zero bit 4 selects combined output
// - function bit zero picks xor or or
// - generator zero pin field routes to pins
// - generator one path carries one or two
// - generator one pin field routes to pins
// - generator two path may halve frequency
// - generator two pin field routes to pins
`timescale 1ns/1ps
module tpg_top
  import tpg_pkg::*;
#(
  parameter bit OSC_DOUBLE = 1'b0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // io space access
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // oscillator ticks
  input wire logic fast_internal_osc_tick,
  input wire logic fast_internal_osc_x2_tick,
  // port pin drive
  output logic [7:0] port_a_level,
  output logic [7:0] port_a_take,
  output logic [7:0] port_b_level,
  output logic [7:0] port_b_take
);

  // shared state
  logic [7:0] clk_cfg_r;
  logic [TPG_DW-1:0] bound_r;
  logic [TPG_DW-1:0] cnt_r;
  logic [TPG_DW-1:0] cnt_nxt;
  logic [2:0] out_r;
  logic half_r;
  logic wave2_d_r;
  logic [7:0] io_rdata_r;
  logic [7:0] port_a_level_r;
  logic [7:0] port_a_take_r;
  logic [7:0] port_b_level_r;
  logic [7:0] port_b_take_r;

  // decoded and per generator wires
  logic run;
  logic src_tick;
  logic step;
  logic wr_clk;
  logic wr_bnd_hi;
  logic wr_bnd_lo;
  logic [2:0] raw;
  logic [2:0] wave;
  logic [2:0] path;
  logic [2:0][5:0] ctl_all;
  logic [2:0][TPG_DW-1:0] duty_all;
  logic [2:0][7:0] ctl_rd;
  logic [2:0] hit_ctl;
  logic [2:0][2:0] pin_code;
  logic half_nxt;
  logic [7:0] rd_nxt;
  logic [7:0] a_take_nxt;
  logic [7:0] b_take_nxt;
  logic [7:0] a_level_nxt;
  logic [7:0] b_level_nxt;

  // clock configuration decode
  assign run = clk_cfg_r[TPG_CLK_EN_BIT];
  assign src_tick = !clk_cfg_r[TPG_CLK_SRC_BIT] ? 1'b1 :
    (OSC_DOUBLE ? fast_internal_osc_x2_tick : fast_internal_osc_tick);
  assign wr_clk = io_wr && io_addr == TPG_ADDR_CLK;
  assign wr_bnd_hi = io_wr && io_addr == TPG_ADDR_BND_HI;
  assign wr_bnd_lo = io_wr && io_addr == TPG_ADDR_BND_LO;

  tpg_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .run(run),
    .src_tick(src_tick),
    .div_sel(clk_cfg_r[TPG_CLK_DIV_LSB +: 3]),
    .step_r(step)
  );

  // clock register and counter bound; bound bit 0 has no writable field
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_cfg_r <= TPG_CLK_RST;
      bound_r <= TPG_BOUND_RST;
    end
    else
    begin
      if (wr_clk)
        clk_cfg_r <= io_wdata;
      if (wr_bnd_hi)
        bound_r[10:3] <= io_wdata;
      if (wr_bnd_lo)
        bound_r[2:1] <= io_wdata[TPG_BND_LO_LSB +: 2];
    end
  end

  // shared counter: wraps to zero after reaching the bound
  assign cnt_nxt = !run ? cnt_r :
    !step ? cnt_r :
    (cnt_r >= bound_r) ? '0 : cnt_r + 11'h001;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // per generator registers and comparator
  for (genvar g = 0; g < TPG_NGEN; g++)
  begin : g_gen
    logic [5:0] ctl_r;
    logic [2:0] stage_r;
    logic [TPG_DW-1:0] duty_r;
    logic wr_ctl;
    logic wr_hi;
    logic wr_lo;

    assign wr_ctl = io_wr && io_addr == TPG_ADDR_CTL[g];
    assign wr_hi = io_wr && io_addr == TPG_ADDR_DTY_HI[g];
    assign wr_lo = io_wr && io_addr == TPG_ADDR_DTY_LO[g];

    // low bits wait in a stage so the comparator never sees a half update
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        ctl_r <= TPG_CTL_RST;
        stage_r <= TPG_STAGE_RST;
        duty_r <= TPG_DUTY_RST;
      end
      else
      begin
        if (wr_ctl)
          ctl_r <= io_wdata[5:0]; // status bit 6 is not stored
        if (wr_lo)
          stage_r <= io_wdata[TPG_DTY_LO_LSB +: 3];
        if (wr_hi)
          duty_r <= {io_wdata, stage_r};
      end
    end

    assign ctl_all[g] = ctl_r;
    assign duty_all[g] = duty_r;
    assign raw[g] = cnt_r < duty_r;
    assign wave[g] = raw[g] ^ ctl_r[TPG_CTL_INV_BIT];
    assign pin_code[g] = ctl_r[TPG_CTL_PIN_LSB +: 3];
    assign hit_ctl[g] = io_addr == TPG_ADDR_CTL[g];
    assign ctl_rd[g] = {1'b0, out_r[g], ctl_r & TPG_CTL_RD_MASK[g]};
  end

  // output path selection
  assign path[0] = !ctl_all[0][TPG_CTL_MODE_BIT] ? wave[0] :
    (ctl_all[0][TPG_CTL_FUNC_BIT] ? (wave[0] | wave[1]) : (wave[0] ^ wave[1]));
  assign path[1] = ctl_all[1][TPG_CTL_MODE_BIT] ? wave[2] : wave[1];
  // halving toggles on each rising edge of generator two
  assign half_nxt = (wave[2] && !wave2_d_r) ? !half_r : half_r;
  assign path[2] = ctl_all[2][TPG_CTL_MODE_BIT] ? half_r : wave[2];

  // pin routing; reserved codes leave every pin undriven
  always_comb
  begin
    a_take_nxt = 8'h00;
    b_take_nxt = 8'h00;
    b_take_nxt[TPG_PORT_B_PIN5] = pin_code[0] == TPG_PIN_C1;
    a_take_nxt[TPG_PORT_A_PIN0] = pin_code[0] == TPG_PIN_C3;
    b_take_nxt[TPG_PORT_B_PIN4] = pin_code[0] == TPG_PIN_C4;
    b_take_nxt[TPG_PORT_B_PIN6] = pin_code[1] == TPG_PIN_C1;
    a_take_nxt[TPG_PORT_A_PIN4] = pin_code[1] == TPG_PIN_C3;
    b_take_nxt[TPG_PORT_B_PIN7] = pin_code[1] == TPG_PIN_C4;
    b_take_nxt[TPG_PORT_B_PIN3] = pin_code[2] == TPG_PIN_C1;
    a_take_nxt[TPG_PORT_A_PIN3] = pin_code[2] == TPG_PIN_C3;
    b_take_nxt[TPG_PORT_B_PIN2] = pin_code[2] == TPG_PIN_C4;
    a_take_nxt[TPG_PORT_A_PIN5] = pin_code[2] == TPG_PIN_C5;
  end

  // a routed pin follows its generator path, other pins are held low
  assign a_level_nxt = a_take_nxt & {1'b0, {2{path[2]}}, path[1], path[2], 2'b00, path[0]};
  assign b_level_nxt = b_take_nxt & {{2{path[1]}}, path[0], path[0], {2{path[2]}}, 2'b00};

  // read data; write-only and unmapped addresses read as zero
  assign rd_nxt = hit_ctl[0] ? ctl_rd[0] :
    hit_ctl[1] ? ctl_rd[1] :
    hit_ctl[2] ? ctl_rd[2] : 8'h00;

  // output stage: every output leaves from a flip-flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_r <= 3'h0;
      half_r <= 1'b0;
      wave2_d_r <= 1'b0;
      io_rdata_r <= 8'h00;
      port_a_level_r <= 8'h00;
      port_a_take_r <= 8'h00;
      port_b_level_r <= 8'h00;
      port_b_take_r <= 8'h00;
    end
    else
    begin
      out_r <= path;
      half_r <= half_nxt;
      wave2_d_r <= wave[2];
      if (io_rd)
        io_rdata_r <= rd_nxt;
      port_a_level_r <= a_level_nxt;
      port_a_take_r <= a_take_nxt;
      port_b_level_r <= b_level_nxt;
      port_b_take_r <= b_take_nxt;
    end
  end

  assign io_rdata = io_rdata_r;
  assign port_a_level = port_a_level_r;
  assign port_a_take = port_a_take_r;
  assign port_b_level = port_b_level_r;
  assign port_b_take = port_b_take_r;

  // checks
  a_stop_holds: assert property (@(posedge clk) disable iff (rst)
    !run ##1 !run |-> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_count_wrap: assert property (@(posedge clk) disable iff (rst)
    (run && step && cnt_r >= bound_r) |=> cnt_r == 11'h000)
    else $error("counter did not wrap at bound");

  a_count_step: assert property (@(posedge clk) disable iff (rst)
    (run && step && cnt_r < bound_r) |=> cnt_r == $past(cnt_r) + 11'h001)
    else $error("counter did not advance by one");

  a_sysclk_div1: assert property (@(posedge clk) disable iff (rst)
    (run && clk_cfg_r[6:4] == 3'h0 && !clk_cfg_r[TPG_CLK_SRC_BIT]) [*2] |-> step)
    else $error("system clock with divide by one missed a step");

  a_bound_low: assert property (@(posedge clk) disable iff (rst)
    wr_bnd_lo |=> bound_r[2:1] == $past(io_wdata[7:6]) && bound_r[0] == 1'b0)
    else $error("bound low bits not taken from bits 7 and 6");

  a_duty_whole: assert property (@(posedge clk) disable iff (rst)
    (io_wr && io_addr == TPG_ADDR_DTY_LO[0]) |=> $stable(duty_all[0]))
    else $error("duty changed on a low register write");

  // the io master leaves one idle cycle between strobes, so the high write lands two cycles later
  a_duty_load: assert property (@(posedge clk) disable iff (rst)
    (io_wr && io_addr == TPG_ADDR_DTY_LO[1]) ##1 !io_wr ##1 (io_wr && io_addr == TPG_ADDR_DTY_HI[1])
    |=> duty_all[1] == {$past(io_wdata), $past(io_wdata[7:5], 3)})
    else $error("duty word not assembled from high and low writes");

  a_status_read: assert property (@(posedge clk) disable iff (rst)
    (io_rd && io_addr == TPG_ADDR_CTL[2]) |=> io_rdata[TPG_CTL_STAT_BIT] == $past(out_r[2]))
    else $error("status bit does not show output level");

  a_invert_path: assert property (@(posedge clk) disable iff (rst)
    !ctl_all[1][TPG_CTL_MODE_BIT] |=> out_r[1] == $past(raw[1] ^ ctl_all[1][TPG_CTL_INV_BIT]))
    else $error("generator one polarity wrong");

  a_combine_func: assert property (@(posedge clk) disable iff (rst)
    ctl_all[0][TPG_CTL_MODE_BIT] |=> out_r[0] == ($past(ctl_all[0][TPG_CTL_FUNC_BIT]) ?
      $past(wave[0] | wave[1]) : $past(wave[0] ^ wave[1])))
    else $error("combined output of generator zero wrong");

  a_half_toggle: assert property (@(posedge clk) disable iff (rst)
    (wave[2] && !wave2_d_r) |=> half_r != $past(half_r))
    else $error("halved output did not toggle on rising edge");

  a_pin_route: assert property (@(posedge clk) disable iff (rst)
    pin_code[0] == TPG_PIN_C3 |=> port_a_take[TPG_PORT_A_PIN0] &&
      port_a_level[TPG_PORT_A_PIN0] == $past(path[0]))
    else $error("generator zero not routed to port a pin 0");

  a_pin_off: assert property (@(posedge clk) disable iff (rst)
    (pin_code[2] == TPG_PIN_OFF) |=> (port_a_take & 8'h28) == 8'h00 && (port_b_take & 8'h0c) == 8'h00)
    else $error("generator two drives a pin while disabled");

  a_route_b7: assert property (@(posedge clk) disable iff (rst)
    pin_code[1] == TPG_PIN_C4 |=> port_b_take[TPG_PORT_B_PIN7] &&
      port_b_level[TPG_PORT_B_PIN7] == $past(path[1]))
    else $error("generator one not routed to port b pin 7");

  a_route_a5: assert property (@(posedge clk) disable iff (rst)
    pin_code[2] == TPG_PIN_C5 |=> port_a_take[TPG_PORT_A_PIN5] &&
      port_a_level[TPG_PORT_A_PIN5] == $past(path[2]))
    else $error("generator two not routed to port a pin 5");

  a_gen2_select: assert property (@(posedge clk) disable iff (rst)
    ctl_all[1][TPG_CTL_MODE_BIT] |=> out_r[1] == $past(wave[2]))
    else $error("generator one path does not carry generator two");

  // a zero duty must keep the raw output low over the whole period
  a_raw_zero: assert property (@(posedge clk) disable iff (rst)
    duty_all[0] == 11'h000 |-> !raw[0])
    else $error("raw output high with zero duty");

  // reserved codes must release every pin of generator zero
  a_reserved_off: assert property (@(posedge clk) disable iff (rst)
    (pin_code[0] == 3'h2 || pin_code[0] > 3'h4) |=> !port_b_take[TPG_PORT_B_PIN5] &&
      !port_a_take[TPG_PORT_A_PIN0] && !port_b_take[TPG_PORT_B_PIN4])
    else $error("generator zero drives a pin on a reserved code");

  c_wrap: cover property (@(posedge clk) disable iff (rst) run && step && cnt_r >= bound_r);
  c_combine: cover property (@(posedge clk) disable iff (rst) ctl_all[0][TPG_CTL_MODE_BIT] && out_r[0]);
  c_half: cover property (@(posedge clk) disable iff (rst) ctl_all[2][TPG_CTL_MODE_BIT] && half_r);
  c_route_b7: cover property (@(posedge clk) disable iff (rst) port_b_take[TPG_PORT_B_PIN7] && port_b_level[7]);

endmodule

// ===== tb/tpg_led_load.sv
// led load on the generator's port pins, port b in the upper byte of pad
// assumes the take/level pairs of tpg_top; a released pin sits at its pull-down
`timescale 1ns/1ps
module tpg_led_load
  import tpg_pkg::*;
(
  // drive from the block
  input wire logic [7:0] a_level,
  input wire logic [7:0] a_take,
  input wire logic [7:0] b_level,
  input wire logic [7:0] b_take,
  // resolved pad levels
  output logic [15:0] pad
);
  // an untaken pin never shows the last driven level, so a stray take is visible
  assign pad = {b_take & b_level, a_take & a_level};
endmodule

// ===== tb/tb_top.sv
// self-checking bench for tpg_top: io-space tasks and pulse measurement on the pads
// assumes a 25 MHz clock and a led load model on every port pin
`timescale 1ns/1ps
module tb_top
  import tpg_pkg::*;
;
  // design connections
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic io_rd = 1'b0;
  logic [7:0] io_rdata;
  logic osc_tick = 1'b0;
  logic osc2_tick = 1'b0;
  logic [7:0] port_a_level;
  logic [7:0] port_a_take;
  logic [7:0] port_b_level;
  logic [7:0] port_b_take;
  logic [15:0] pad;
  logic [2:0] tcnt = 3'h0;
  int error_cnt = 0;
  int checks = 0;
  // routing table: control address, value, pad, period, high width, take
  logic [5:0] t_a [17] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h26, 6'h26, 6'h26, 6'h26, 6'h26,
    6'h2c, 6'h2c, 6'h2c, 6'h2c, 6'h2c};
  logic [7:0] t_v [17] = '{8'h02, 8'h06, 8'h08, 8'h04, 8'h22, 8'h12, 8'h13, 8'h02, 8'h06, 8'h08, 8'h0a, 8'h12,
    8'h02, 8'h06, 8'h08, 8'h0a, 8'h12};
  int t_p [17] = '{13, 0, 12, 13, 13, 13, 13, 14, 4, 15, 14, 14, 11, 3, 10, 5, 11};
  int t_per [17] = '{11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 11, 22};
  int t_hi [17] = '{4, 4, 4, 0, 7, 4, 8, 8, 8, 8, 0, 2, 2, 2, 2, 2, 11};
  logic [15:0] t_tk [17] = '{16'h2000, 16'h0001, 16'h1000, 16'h0000, 16'h2000, 16'h2000, 16'h2000, 16'h4000,
    16'h0010, 16'h8000, 16'h0000, 16'h4000, 16'h0800, 16'h0008, 16'h0400, 16'h0020, 16'h0800};

  tpg_top #(.OSC_DOUBLE(1'b0)) i_tpg_top (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rd(io_rd), .io_rdata(io_rdata), .fast_internal_osc_tick(osc_tick),
    .fast_internal_osc_x2_tick(osc2_tick), .port_a_level(port_a_level), .port_a_take(port_a_take),
    .port_b_level(port_b_level), .port_b_take(port_b_take));

  tpg_led_load i_tpg_led_load (.a_level(port_a_level), .a_take(port_a_take), .b_level(port_b_level),
    .b_take(port_b_take), .pad(pad));

  always #20 clk = ~clk;

  // oscillator tick every fifth cycle; the doubled tick runs at another rate so a wrong pick shows
  always @(posedge clk)
  begin
    tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    osc_tick <= (tcnt == 3'h4);
    osc2_tick <= tcnt[0];
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write; an edge passes between strobes so back-to-back calls never collide
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(posedge clk);
    chk(nm, {8'h00, e}, {8'h00, io_rdata & m});
  endtask

  // settle, then time the first whole pulse on a pad: high width and rise-to-rise period
  task automatic meas(input int p, input int per, input int hi, input logic [15:0] tk, input string nm);
    int n;
    int h;
    int q;
    logic prev;
    n = 0;
    h = 0;
    q = 0;
    repeat (2 * per + 4) @(posedge clk);
    chk({nm, "_take"}, tk, {port_b_take, port_a_take});
    prev = pad[p];
    for (int i = 0; i < 4 * per + 8; i++)
    begin
      @(posedge clk);
      if (pad[p] === 1'b1 && prev === 1'b0)
        q++;
      if (q == 1 && pad[p] === 1'b1)
        h++;
      if (q == 1)
        n++;
      prev = pad[p];
    end
    chk({nm, "_hi"}, h, hi);
    chk({nm, "_per"}, hi == 0 ? 0 : per, n);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(6'h20, 8'hff, 8'h00, "ctl0_rst");
    rd(6'h21, 8'hff, 8'h00, "clk_wo");
    rd(6'h3f, 8'hff, 8'h00, "unmapped");
    wr(6'h26, 8'hff);
    rd(6'h26, 8'hbf, 8'h3f, "ctl1_rw");
    wr(6'h26, 8'h00);
    wr(6'h20, 8'hff);
    rd(6'h20, 8'hbf, 8'h0f, "ctl0_rw");
    wr(6'h20, 8'h22);
    repeat (4) @(posedge clk);
    rd(6'h20, 8'hff, 8'h42, "ctl0_status");
    wr(6'h24, 8'h01);
    wr(6'h25, 8'h40);
    wr(6'h23, 8'h80);
    wr(6'h22, 8'h00);
    wr(6'h29, 8'h00);
    wr(6'h28, 8'h01);
    wr(6'h2f, 8'h40);
    wr(6'h2e, 8'h00);
    wr(6'h20, 8'h02);
    for (int k = 0; k < 8; k++)
    begin
      wr(6'h21, {1'b1, k[2:0], 4'h0});
      meas(13, 11 << k, 4 << k, 16'h2000, $sformatf("div%0d", k));
    end
    wr(6'h21, 8'h80);
    wr(6'h20, 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      wr(t_a[i], t_v[i]);
      meas(t_p[i], t_per[i], t_hi[i], t_tk[i], $sformatf("route%0d", i));
      wr(t_a[i], 8'h00);
    end
    wr(6'h20, 8'h02);
    wr(6'h23, 8'h20);
    meas(13, 11, 4, 16'h2000, "low_only");
    wr(6'h22, 8'h00);
    meas(13, 11, 1, 16'h2000, "low_high");
    wr(6'h23, 8'h80);
    wr(6'h22, 8'h00);
    wr(6'h21, 8'h81);
    meas(13, 55, 20, 16'h2000, "osc_src");
    wr(6'h21, 8'h01);
    meas(13, 11, 0, 16'h2000, "stopped");
    report_and_stop;
  end

  // watchdog well beyond the longest expected run
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
endmodule
